// >>> pkg/sfpce_pkg.sv
// Purpose: Shared constants and types for the serial flash program command engine.
// Assumes: Commands are six bits, sent least significant bit first.
// Notes: Payloads are sixteen clocks: start bit, fourteen data bits, stop bit.
package sfpce_pkg;
  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  localparam logic [5:0] CMD_LOAD_CFG = 6'h01;
  localparam logic [5:0] CMD_LOAD_DATA = 6'h02;
  localparam logic [5:0] CMD_READ_DATA = 6'h03;
  localparam logic [5:0] CMD_INC_ADDR = 6'h04;
  localparam logic [5:0] CMD_BEGIN_INT = 6'h05;
  localparam logic [5:0] CMD_BEGIN_EXT = 6'h06;
  localparam logic [5:0] CMD_END_EXT = 6'h07;
  localparam logic [5:0] CMD_BULK_ERASE = 6'h08;
  localparam logic [5:0] CMD_RESET_ADDR = 6'h09;
  localparam logic [4:0] CMD_LAST_BIT = 5'h05;
  localparam logic [4:0] PAYLOAD_LAST_BIT = 5'h0F;
  // ----------------------------------------------------------------
  // Address map and words
  // ----------------------------------------------------------------
  localparam logic [15:0] CFG_BASE = 16'h8000;
  localparam logic [15:0] ERASE_ALL_TOP = 16'h8008;
  localparam logic [11:0] CFG_PAGE = 12'h800;
  localparam logic [3:0] USER_ID_LAST = 4'h3;
  localparam logic [3:0] DEVID_IDX = 4'h6;
  localparam logic [3:0] CFG1_IDX = 4'h7;
  localparam logic [3:0] CFG2_IDX = 4'h8;
  localparam int CP_BIT = 7;
  localparam logic [13:0] ERASED_WORD = 14'h3FFF;
  localparam logic [13:0] ZERO_WORD = 14'h0000;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam real CLK_PERIOD_NS = 8.0;
  localparam real INTERNAL_WRITE_TIME_PM_MS = 2.5;
  localparam real INTERNAL_WRITE_TIME_CFG_MS = 5;
  localparam int INT_PM_CYC = int'($floor(INTERNAL_WRITE_TIME_PM_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int INT_CFG_CYC = int'($floor(INTERNAL_WRITE_TIME_CFG_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int BULK_ERASE_CYC = 1000;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LS_CMD = 2'b00, LS_LOAD = 2'b01, LS_READ = 2'b10} sfpce_lstate_t;
  typedef enum logic {CS_IDLE = 1'b0, CS_BUSY = 1'b1} sfpce_cstate_t;
endpackage

// >>> logic/sfpce_engine.sv
// Purpose: Device-side engine that takes serial programming commands into flash.
// Assumes: The programmer keeps its spacing and timing obligations.
// Notes: Link logic runs on the serial clock; storage runs on clk_i.
// Operation
// - Load command puts one word in latches.
// - Read shifts addressed word out from rise two.
// - Data pin drives from fall one to sixteen.
// - Protected reads of program memory return zeros.
// - Internal write self-times; programmer waits its time.
// - Internal write needs no end command.
// - Writing does not erase the location first.
// - External writes leave configuration words unchanged.
// - Low address erase keeps user identification words.
// - Configuration address erase clears user words too.
// - Erase completes only after its erase time.
// - Each load fills one latch until commit.
// - Latches follow low address bits within row.
// - Extra loads overwrite earlier latch contents.
// - Protection refuses program memory writes.
// - User and configuration words stay accessible under protection.
// - Protection active when its bit reads zero.
// - Only bulk erase clears protection.
// - Protection bit is bit seven, first word.
`timescale 1ns/100ps
module sfpce_engine #(
  parameter int PM_WORDS = 64,
  parameter int LATCH_LOG2 = 3,
  parameter logic [13:0] DEV_ID_WORD = 14'h0000, // Arbitrary identity value.
  parameter int INT_PM_CYC = sfpce_pkg::INT_PM_CYC,
  parameter int INT_CFG_CYC = sfpce_pkg::INT_CFG_CYC,
  parameter int BULK_ERASE_CYC = sfpce_pkg::BULK_ERASE_CYC
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic serial_prog_clk_i,
  input wire logic serial_prog_data_pin_i,
  output logic serial_prog_data_pin_o,
  output logic serial_prog_data_pin_oe_o,
  output logic busy_o,
  output logic code_protect_active_o
);
  localparam int LATCH_N = 1 << LATCH_LOG2;
  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------
  sfpce_pkg::sfpce_lstate_t lst_q;
  logic [4:0] bit_cnt_q;
  logic [15:0] sh_q;
  logic [5:0] cmd_q;
  logic [13:0] word_q;
  logic tgl_q;
  logic oe_q;
  logic [14:0] rdsh_q;
  logic dout_q;
  logic [13:0] rd_word_q;
  wire [15:0] sh_d = {serial_prog_data_pin_i, sh_q[15:1]};
  wire [5:0] cmd_d = sh_d[15:10];
  wire cmd_done = (lst_q == sfpce_pkg::LS_CMD) && (bit_cnt_q == sfpce_pkg::CMD_LAST_BIT);
  wire pay_done = (lst_q != sfpce_pkg::LS_CMD) && (bit_cnt_q == sfpce_pkg::PAYLOAD_LAST_BIT);
  wire cmd_is_load = (cmd_d == sfpce_pkg::CMD_LOAD_DATA) || (cmd_d == sfpce_pkg::CMD_LOAD_CFG);

  // Bits are taken on falling edges; commands and payloads are framed here.
  always_ff @(negedge serial_prog_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      lst_q <= sfpce_pkg::LS_CMD;
      bit_cnt_q <= 5'h00;
      sh_q <= 16'h0000;
      cmd_q <= 6'h00;
      word_q <= 14'h0000;
      tgl_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      sh_q <= sh_d;
      bit_cnt_q <= (cmd_done || pay_done) ? 5'h00 : bit_cnt_q + 5'h01;
      if (cmd_done)
      begin
        cmd_q <= cmd_d;
        if (cmd_is_load)
          lst_q <= sfpce_pkg::LS_LOAD;
        else if (cmd_d == sfpce_pkg::CMD_READ_DATA)
          lst_q <= sfpce_pkg::LS_READ;
        else
          tgl_q <= ~tgl_q;
      end
      if (lst_q == sfpce_pkg::LS_READ)
        oe_q <= !pay_done;
      if (pay_done)
      begin
        lst_q <= sfpce_pkg::LS_CMD;
        if (lst_q == sfpce_pkg::LS_LOAD)
        begin
          word_q <= sh_d[14:1];
          tgl_q <= ~tgl_q;
        end
      end
    end
  end

  // Read data leaves on rising edges: start bit, then word from the second rise.
  always_ff @(posedge serial_prog_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdsh_q <= 15'h0000;
      dout_q <= 1'b0;
    end
    else
    begin
      rdsh_q <= (lst_q == sfpce_pkg::LS_READ) ? (rdsh_q >> 1) : {rd_word_q, 1'b0};
      dout_q <= (lst_q == sfpce_pkg::LS_READ) ? rdsh_q[0] : 1'b0;
    end
  end

  assign serial_prog_data_pin_o = dout_q;
  assign serial_prog_data_pin_oe_o = oe_q;
  // ----------------------------------------------------------------
  // Crossing into the core clock
  // ----------------------------------------------------------------
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_s3_q;

  // The command and word hold still for the whole next command, so only the toggle syncs.
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end
    else
    begin
      tgl_s1_q <= tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end
  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  sfpce_pkg::sfpce_cstate_t cst_q;
  logic [19:0] cnt_q;
  logic [15:0] addr_q;
  logic [13:0] latch_q [LATCH_N];
  logic [LATCH_N-1:0] lv_q;
  logic [13:0] pm_q [PM_WORDS];
  logic [13:0] cfg_q [16];
  wire evt = (tgl_s2_q ^ tgl_s3_q) && (cst_q == sfpce_pkg::CS_IDLE);
  wire ld_go = evt && ((cmd_q == sfpce_pkg::CMD_LOAD_DATA) || (cmd_q == sfpce_pkg::CMD_LOAD_CFG));
  wire int_go = evt && (cmd_q == sfpce_pkg::CMD_BEGIN_INT);
  wire ext_go = evt && (cmd_q == sfpce_pkg::CMD_BEGIN_EXT);
  wire wr_go = int_go || ext_go;
  wire erase_go = evt && (cmd_q == sfpce_pkg::CMD_BULK_ERASE);
  wire in_cfg = (addr_q[15:4] == sfpce_pkg::CFG_PAGE);
  wire in_pm = !addr_q[15];
  wire cp_active = !cfg_q[sfpce_pkg::CFG1_IDX][sfpce_pkg::CP_BIT];
  wire erase_lo = erase_go && in_pm;
  wire erase_hi = erase_go && (addr_q >= sfpce_pkg::CFG_BASE) && (addr_q <= sfpce_pkg::ERASE_ALL_TOP);
  wire erase_any = erase_lo || erase_hi;
  wire pm_wr_ok = wr_go && in_pm && !cp_active;
  wire cfg_wr_ok = wr_go && in_cfg;
  wire [LATCH_LOG2-1:0] lidx = addr_q[LATCH_LOG2-1:0];
  // Load configuration moves the address to the page base, so its word lands in that latch.
  wire ld_cfg = evt && (cmd_q == sfpce_pkg::CMD_LOAD_CFG);
  wire [LATCH_LOG2-1:0] ld_idx = ld_cfg ? sfpce_pkg::CFG_BASE[LATCH_LOG2-1:0] : lidx;
  wire [19:0] wr_time = in_cfg ? 20'(INT_CFG_CYC) : 20'(INT_PM_CYC);
  wire [19:0] go_time = erase_any ? 20'(BULK_ERASE_CYC) : wr_time;

  // Shared address register and busy timer for self-timed operations.
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cst_q <= sfpce_pkg::CS_IDLE;
      cnt_q <= 20'h00000;
      addr_q <= 16'h0000;
    end
    else
    begin
      if (evt && (cmd_q == sfpce_pkg::CMD_LOAD_CFG))
        addr_q <= sfpce_pkg::CFG_BASE;
      else if (evt && (cmd_q == sfpce_pkg::CMD_INC_ADDR))
        addr_q <= addr_q + 16'h0001;
      else if (evt && (cmd_q == sfpce_pkg::CMD_RESET_ADDR))
        addr_q <= 16'h0000;
      if (int_go || erase_any)
      begin
        cst_q <= sfpce_pkg::CS_BUSY;
        cnt_q <= go_time;
      end
      else if (cst_q == sfpce_pkg::CS_BUSY)
      begin
        cnt_q <= cnt_q - 20'h00001;
        if (cnt_q <= 20'h00001)
          cst_q <= sfpce_pkg::CS_IDLE;
      end
    end
  end

  // One latch per low address value; a later load to it overwrites.
  for (genvar l = 0; l < LATCH_N; l++)
  begin : g_latch
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
      begin
        latch_q[l] <= sfpce_pkg::ERASED_WORD;
        lv_q[l] <= 1'b0;
      end
      else if (ld_go && (ld_idx == LATCH_LOG2'(l)))
      begin
        latch_q[l] <= word_q;
        lv_q[l] <= 1'b1;
      end
      else if (wr_go)
        lv_q[l] <= 1'b0;
    end
  end

  // Program words: row picked by upper address bits; data only clears bits.
  for (genvar i = 0; i < PM_WORDS; i++)
  begin : g_pm
    localparam logic [15:0] IA = 16'(i);
    wire hit = pm_wr_ok && (addr_q[15:LATCH_LOG2] == IA[15:LATCH_LOG2]) && lv_q[i % LATCH_N];
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
        pm_q[i] <= sfpce_pkg::ERASED_WORD;
      else if (erase_any)
        pm_q[i] <= sfpce_pkg::ERASED_WORD;
      else if (hit)
        pm_q[i] <= pm_q[i] & latch_q[i % LATCH_N];
    end
  end

  // Configuration page: user words, identity word and two configuration words.
  for (genvar j = 0; j < 16; j++)
  begin : g_cfg
    localparam logic [3:0] JA = 4'(j);
    localparam bit IS_USER = (JA <= sfpce_pkg::USER_ID_LAST);
    localparam bit IS_CFG = (JA == sfpce_pkg::CFG1_IDX) || (JA == sfpce_pkg::CFG2_IDX);
    wire row = (addr_q[3:LATCH_LOG2] == JA[3:LATCH_LOG2]);
    wire ok = (IS_USER || (IS_CFG && int_go));
    wire hit = cfg_wr_ok && row && lv_q[j % LATCH_N] && ok;
    wire ers = (IS_CFG && erase_any) || (IS_USER && erase_hi);
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
        cfg_q[j] <= (JA == sfpce_pkg::DEVID_IDX) ? DEV_ID_WORD : sfpce_pkg::ERASED_WORD;
      else if (ers)
        cfg_q[j] <= sfpce_pkg::ERASED_WORD;
      else if (hit)
        cfg_q[j] <= cfg_q[j] & latch_q[j % LATCH_N];
    end
  end

  // Word presented for reads; re-registered every core clock from the addressed location.
  wire [13:0] pm_sel = (int'(addr_q) < PM_WORDS) ? pm_q[addr_q[$clog2(PM_WORDS)-1:0]] : 14'h0000;
  wire [13:0] rd_d = in_pm ? (cp_active ? sfpce_pkg::ZERO_WORD : pm_sel)
                   : (in_cfg ? cfg_q[addr_q[3:0]] : sfpce_pkg::ZERO_WORD);
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rd_word_q <= 14'h0000;
    else
      rd_word_q <= rd_d;
  end

  assign busy_o = (cst_q == sfpce_pkg::CS_BUSY);
  assign code_protect_active_o = cp_active;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Counts falls with the pin driven, so the drive window needs no long repetition.
  logic [4:0] oe_run_q;
  always_ff @(negedge serial_prog_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      oe_run_q <= 5'h00;
    else
      oe_run_q <= oe_q ? oe_run_q + 5'h01 : 5'h00;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_load_latch_fill: assert property (ld_go |=> latch_q[$past(ld_idx)] == $past(word_q))
    else $error("Load did not fill the addressed latch.");
  chk_read_oe_span: assert property (@(negedge serial_prog_clk_i) disable iff (!reset_n_i)
    $fell(oe_q) |-> oe_run_q == sfpce_pkg::PAYLOAD_LAST_BIT)
    else $error("Data pin drive window is not sixteen falls.");
  chk_read_prot_zero: assert property (cp_active && in_pm |=> rd_word_q == 14'h0000)
    else $error("Protected read returned stored data.");
  chk_int_self_time: assert property (int_go |=> busy_o [*2])
    else $error("Internal write did not start its timer.");
  chk_no_erase_first: assert property (g_pm[8].hit |=> pm_q[8] == ($past(pm_q[8]) & $past(latch_q[0])))
    else $error("Write did not merge onto the old word.");
  chk_ext_cfg_keep: assert property (ext_go && in_cfg |=> $stable(cfg_q[sfpce_pkg::CFG1_IDX]) && $stable(cfg_q[sfpce_pkg::CFG2_IDX]))
    else $error("External write changed a configuration word.");
  chk_erase_keep_user: assert property (erase_lo |=> $stable(cfg_q[0]) && cfg_q[sfpce_pkg::CFG1_IDX] == sfpce_pkg::ERASED_WORD)
    else $error("Low erase touched user words or missed configuration.");
  chk_erase_all_user: assert property (erase_hi |=> cfg_q[0] == sfpce_pkg::ERASED_WORD)
    else $error("High erase kept user words.");
  chk_prot_refuse: assert property (wr_go && in_pm && cp_active |=> $stable(pm_q[8]))
    else $error("Protected program memory was written.");
  chk_cp_only_erase: assert property (cp_active ##1 !cp_active |-> $past(erase_any))
    else $error("Protection cleared without bulk erase.");

  cov_load_then_int: cover property (ld_go ##[1:300] int_go);
  cov_ext_write: cover property (ext_go);
  cov_erase_hi: cover property (erase_hi);
  cov_prot_read: cover property (cp_active && in_pm);
endmodule // sfpce_engine

// >>> tb/sfpce_prog_model.sv
// Purpose: Behavioural programmer that drives the serial clock and data pin.
// Assumes: A clock period of 80 ns; the clock stands low between frames.
// Notes: Data changes only while the clock is low; bits go out LSB first.
`timescale 1ns/100ps
module sfpce_prog_model (
  output logic sclk_o,
  output logic sdat_o,
  output logic sdat_oe_o,
  input wire logic pin_i,
  input wire logic dev_oe_i
);
  // The line is driven by the programmer except during a read payload.
  initial
  begin
    sclk_o = 1'b0;
    sdat_o = 1'b0;
    sdat_oe_o = 1'b1;
  end

  // Shifts n bits out, one per clock, sampled by the device on the fall.
  task automatic shift(input logic [15:0] val, input int n);
    for (int i = 0; i < n; i++)
    begin
      sdat_o = val[i];
      #20 sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
      #20;
    end
  endtask

  // Sends a six-bit command after an idle gap.
  task automatic cmd(input logic [5:0] c);
    #200;
    shift({10'h000, c}, 6);
  endtask

  // Sends a command with a start bit, fourteen data bits and a stop bit.
  task automatic load(input logic [5:0] c, input logic [13:0] w);
    cmd(c);
    shift({1'b0, w, 1'b0}, 16);
  endtask

  // Releases the line and samples the word late in each high phase.
  task automatic read(output logic [13:0] w, output logic oe_mid);
    cmd(sfpce_pkg::CMD_READ_DATA);
    sdat_oe_o = 1'b0;
    w = 14'h0000;
    oe_mid = 1'b0;
    for (int i = 1; i <= 16; i++)
    begin
      #20 sclk_o = 1'b1;
      #39;
      if (i >= 2 && i <= 15) w[i-2] = pin_i;
      if (i == 2) oe_mid = dev_oe_i;
      #1 sclk_o = 1'b0;
      #20;
    end
    sdat_oe_o = 1'b1;
  endtask
endmodule // sfpce_prog_model

// >>> tb/test_serial_flash_program_command_engine.sv
// Purpose: Self-checking bench for the serial flash program command engine.
// Assumes: Short busy counts of 20, 40 and 30 core cycles.
// Notes: A released data line shows the inverse of the device's last drive.
`timescale 1ns/100ps
module test_serial_flash_program_command_engine;
  logic clk_i, reset_n_i, sclk, m_dat, m_oe, pin_o, pin_oe, busy, cp_act, oe_mid;
  logic [13:0] rd;
  wire logic pin = pin_oe ? pin_o : (m_oe ? m_dat : ~pin_o);
  int error_cnt = 0;
  int n_compared = 0;
  // External write window and discharge delay, scaled down a thousandfold for run length.
  localparam int EXT_WAIT_NS = 1300;
  localparam int DIS_WAIT_NS = 300;

  sfpce_engine #(.INT_PM_CYC(20), .INT_CFG_CYC(40), .BULK_ERASE_CYC(30)) dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .serial_prog_clk_i(sclk),
    .serial_prog_data_pin_i(pin), .serial_prog_data_pin_o(pin_o),
    .serial_prog_data_pin_oe_o(pin_oe), .busy_o(busy), .code_protect_active_o(cp_act));
  sfpce_prog_model prog (.sclk_o(sclk), .sdat_o(m_dat), .sdat_oe_o(m_oe), .pin_i(pin),
    .dev_oe_i(pin_oe));

  // Core clock of 8 ns.
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic check(input logic [13:0] got, input logic [13:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Reads the current word and checks the pin direction around the payload.
  task automatic rd_chk(input logic [13:0] exp);
    prog.read(rd, oe_mid);
    check(rd, exp);
    check({13'h0, oe_mid}, 14'h0001);
    check({13'h0, pin_oe}, 14'h0000);
  endtask

  // Moves the address to n from zero.
  task automatic go(input int n);
    prog.cmd(sfpce_pkg::CMD_RESET_ADDR);
    for (int i = 0; i < n; i++) prog.cmd(sfpce_pkg::CMD_INC_ADDR);
  endtask

  // Counts how long busy stands after a timed command.
  task automatic run_busy(input int n);
    int cnt;
    cnt = 0;
    for (int i = 0; i < 3000 && !(cnt > 0 && busy === 1'b0); i++)
    begin
      @(negedge clk_i);
      if (busy === 1'b1) cnt++;
    end
    check(14'(cnt >= n && cnt <= n + 1), 14'h0001);
  endtask

  task automatic t_reset;
    check({12'h0, busy, cp_act}, 14'h0000);
    rd_chk(sfpce_pkg::ERASED_WORD);
  endtask

  task automatic t_latch;
    go(8);
    prog.load(sfpce_pkg::CMD_LOAD_DATA, 14'h1111);
    prog.load(sfpce_pkg::CMD_LOAD_DATA, 14'h2AAA);
    prog.cmd(sfpce_pkg::CMD_INC_ADDR);
    prog.load(sfpce_pkg::CMD_LOAD_DATA, 14'h0555);
    go(8);
    rd_chk(14'h3FFF);
    go(10);
    prog.cmd(sfpce_pkg::CMD_BEGIN_INT);
    run_busy(20);
    go(8);
    rd_chk(14'h2AAA);
    prog.cmd(sfpce_pkg::CMD_INC_ADDR);
    rd_chk(14'h0555);
    go(8);
    prog.load(sfpce_pkg::CMD_LOAD_DATA, 14'h1C3C);
    prog.cmd(sfpce_pkg::CMD_BEGIN_INT);
    run_busy(20);
    rd_chk(14'h0828);
  endtask

  task automatic t_ext;
    prog.load(sfpce_pkg::CMD_LOAD_CFG, 14'h3FFF);
    for (int i = 0; i < 7; i++) prog.cmd(sfpce_pkg::CMD_INC_ADDR);
    prog.load(sfpce_pkg::CMD_LOAD_DATA, 14'h0F7F);
    prog.cmd(sfpce_pkg::CMD_BEGIN_EXT);
    #(EXT_WAIT_NS) prog.cmd(sfpce_pkg::CMD_END_EXT);
    #(DIS_WAIT_NS);
    check({13'h0, busy}, 14'h0000);
    rd_chk(14'h3FFF);
  endtask

  task automatic t_protect;
    prog.load(sfpce_pkg::CMD_LOAD_CFG, 14'h1234);
    for (int i = 0; i < 7; i++) prog.cmd(sfpce_pkg::CMD_INC_ADDR);
    prog.load(sfpce_pkg::CMD_LOAD_DATA, 14'h3F7F);
    prog.cmd(sfpce_pkg::CMD_BEGIN_INT);
    run_busy(40);
    check({13'h0, cp_act}, 14'h0001);
    rd_chk(14'h3F7F);
    go(8);
    rd_chk(sfpce_pkg::ZERO_WORD);
    prog.load(sfpce_pkg::CMD_LOAD_DATA, 14'h0000);
    prog.cmd(sfpce_pkg::CMD_BEGIN_INT);
    run_busy(20);
    rd_chk(sfpce_pkg::ZERO_WORD);
  endtask

  task automatic t_erase;
    go(0);
    prog.cmd(sfpce_pkg::CMD_BULK_ERASE);
    run_busy(30);
    check({13'h0, cp_act}, 14'h0000);
    go(8);
    rd_chk(14'h3FFF);
    prog.load(sfpce_pkg::CMD_LOAD_CFG, 14'h3FFF);
    rd_chk(14'h1234);
    prog.cmd(sfpce_pkg::CMD_BULK_ERASE);
    run_busy(30);
    rd_chk(14'h3FFF);
  endtask

  // Reset for five cycles, then the scenarios in order.
  initial
  begin
    reset_n_i = 1'b0;
    repeat (5) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    t_reset();
    t_latch();
    t_ext();
    t_protect();
    t_erase();
    print_verdict();
  end

  // Cuts a hang short well beyond the expected run time.
  initial
  begin
    #600000;
    error_cnt++;
    print_verdict();
  end
endmodule // test_serial_flash_program_command_engine
